// ---- fsce_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef FSCE_REGS_SVH
`define FSCE_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define FSCE_CTRL_OFS      8'h00
`define FSCE_OSC_CTRL_OFS  8'h04
`define FSCE_STAT_OFS      8'h08
`define FSCE_IRQ_STAT_OFS  8'h0c
`define FSCE_IRQ_MASK_OFS  8'h10

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
// control: [1:0] spare, read back, [2] blocks idle wake in fail-safe when set,
// [3] power-managed entry strobe (self clearing), [4] idle select
`define FSCE_CTRL_MODE_LSB 0
`define FSCE_CTRL_FIE_BIT  2
`define FSCE_CTRL_PME_BIT  3
`define FSCE_CTRL_IDLE_BIT 4
// oscillator control: [1:0] source for power-managed mode
`define FSCE_OSC_SRC_LSB   0
// status: [0] startup status, [1] on internal rc, [2] monitor on,
// [3] primary enabled, [4] cpu running
`define FSCE_ST_OSC_STARTUP_STATUS_BIT_BIT   0
`define FSCE_ST_RC_BIT     1
`define FSCE_ST_MON_BIT    2
`define FSCE_ST_PEN_BIT    3
`define FSCE_ST_RUN_BIT    4
// irq status/mask: [0] osc failure flag, [1] switchover event
`define FSCE_IRQ_FAIL_BIT  0
`define FSCE_IRQ_SW_BIT    1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define FSCE_CTRL_RST      8'h00
`define FSCE_OSC_CTRL_RST  2'h0
`define FSCE_MASK_RST      2'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FSCE_CLK_MHZ       200
`define FSCE_OST_US        10
`define FSCE_PLL_US        2000
`define FSCE_OST_CYC       (`FSCE_OST_US * `FSCE_CLK_MHZ)
`define FSCE_PLL_CYC       (`FSCE_PLL_US * `FSCE_CLK_MHZ)
// missing-edge window of the monitor, in system clocks
`define FSCE_MON_CYC       64

`endif

// ---- fsce_pkg.sv ----
// types shared by the fail-safe clock exit control
package fsce_pkg;

  // primary oscillator modes selected by the configuration word
  typedef enum logic [1:0] {
    FSCE_EXT_CLK  = 2'h0,
    FSCE_INT_RC   = 2'h1,
    FSCE_XTAL     = 2'h2,
    FSCE_XTAL_PLL = 2'h3
  } fsce_mode_type;

  typedef enum logic [1:0] {
    FSCE_ST_START,
    FSCE_ST_PRIMARY,
    FSCE_ST_FAILSAFE,
    FSCE_ST_PM
  } fsce_state_type;

endpackage

// ---- fsce_ctrl.sv ----
// fail-safe clock monitor exit and start-up control with wishbone regs
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`include "fsce_regs.svh"

module fsce_ctrl #(
  parameter int unsigned OST_CYC = `FSCE_OST_CYC,
  parameter int unsigned PLL_CYC = `FSCE_PLL_CYC,
  parameter int unsigned MON_CYC = `FSCE_MON_CYC
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // oscillator side
  input  wire logic                  prim_clk_i,
  input  wire logic                  wake_evt_i,
  input  wire logic [1:0]            cfg_mode_i,
  output logic                       prim_en_o,
  output logic                       sel_rc_o,
  output fsce_pkg::fsce_mode_type    clk_src_o,
  output logic                       mon_en_o,
  output logic                       cpu_run_o,
  output logic                       irq_o
);
  import fsce_pkg::*;

  localparam int unsigned TMR_MAX = OST_CYC + PLL_CYC;

  initial begin
    if (OST_CYC < 1 || PLL_CYC < 1 || MON_CYC < 2 || MON_CYC > 255 ||
        TMR_MAX >= 2**24)
      $error("fsce_ctrl: timing parameters out of range");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [2:0] pclk_sync_reg;
  logic [1:0] wake_sync_reg;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pclk_sync_reg <= 3'h0;
      wake_sync_reg <= 2'h0;
    end else begin
      pclk_sync_reg <= {pclk_sync_reg[1:0], prim_clk_i};
      wake_sync_reg <= {wake_sync_reg[0], wake_evt_i};
    end
  end
  // edge seen only between second and third stage
  logic pclk_edge;
  logic wake;
  assign pclk_edge = pclk_sync_reg[2] ^ pclk_sync_reg[1];
  assign wake      = wake_sync_reg[1];
  // configuration word is static while reset is held; these stages
  // carry no reset so they have loaded it by the time reset ends
  logic [3:0] cfg_sync_reg;
  always_ff @(posedge clk_i) begin
    cfg_sync_reg <= {cfg_sync_reg[1:0], cfg_mode_i};
  end

  // ------------------------------------------------------------
  // registers and bus
  // ------------------------------------------------------------
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [1:0]  osc_reg, osc_next;
  logic [1:0]  irq_st_reg, irq_st_next;
  logic [1:0]  mask_reg, mask_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        ack_reg, ack_next;
  logic        irq_reg, irq_next;

  fsce_state_type st_reg, st_next;
  logic [23:0]    tmr_reg, tmr_next;
  logic [7:0]     mon_reg, mon_next;
  logic           osc_startup_status_bit_reg, osc_startup_status_bit_next;
  logic           pen_reg, pen_next;
  logic           rc_reg, rc_next;
  logic           mon_on_reg, mon_on_next;
  logic           run_reg, run_next;
  fsce_mode_type  src_reg, src_next;

  logic          bus_req, wr, rd;
  logic          pm_entry, fail_det, sw_evt;
  fsce_mode_type cfg_mode;
  logic [4:0]    status;

  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
  // a write lands on the edge at which the master sees ack high
  assign wr       = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i &&
                    wb_sel_i[0];
  assign rd       = bus_req && !wb_we_i;
  assign cfg_mode = fsce_mode_type'(cfg_sync_reg[3:2]);
  assign pm_entry = ctrl_reg[`FSCE_CTRL_PME_BIT];
  assign status   = {run_reg, pen_reg, mon_on_reg, rc_reg, osc_startup_status_bit_reg};

  always_comb begin
    ctrl_next   = ctrl_reg;
    osc_next    = osc_reg;
    mask_next   = mask_reg;
    irq_st_next = irq_st_reg;
    rdat_next   = rdat_reg;
    ack_next    = bus_req;
    ctrl_next[`FSCE_CTRL_PME_BIT] = 1'b0;
    if (wr) begin
      case (wb_adr_i)
        `FSCE_CTRL_OFS:     ctrl_next = wb_dat_i[7:0];
        `FSCE_OSC_CTRL_OFS: osc_next  = wb_dat_i[1:0];
        `FSCE_IRQ_MASK_OFS: mask_next = wb_dat_i[1:0];
        default:            ;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        `FSCE_CTRL_OFS:     rdat_next = {24'h0, ctrl_reg};
        `FSCE_OSC_CTRL_OFS: rdat_next = {30'h0, osc_reg};
        `FSCE_STAT_OFS:     rdat_next = {27'h0, status};
        `FSCE_IRQ_STAT_OFS: rdat_next = {30'h0, irq_st_reg};
        `FSCE_IRQ_MASK_OFS: rdat_next = {30'h0, mask_reg};
        default:            rdat_next = 32'h0;
      endcase
      if (wb_adr_i == `FSCE_IRQ_STAT_OFS)
        irq_st_next = 2'h0;
    end
    // a new event wins over the read clear
    if (fail_det)
      irq_st_next[`FSCE_IRQ_FAIL_BIT] = 1'b1;
    if (sw_evt)
      irq_st_next[`FSCE_IRQ_SW_BIT] = 1'b1;
    // rule 6: osc control holds reset value until startup status is set or power-managed entry
    if (st_reg == FSCE_ST_START && !osc_startup_status_bit_reg && !pm_entry)
      osc_next = `FSCE_OSC_CTRL_RST;
    irq_next = |(irq_st_next & mask_reg);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg   <= `FSCE_CTRL_RST;
      osc_reg    <= `FSCE_OSC_CTRL_RST;
      mask_reg   <= `FSCE_MASK_RST;
      irq_st_reg <= 2'h0;
      rdat_reg   <= 32'h0;
      ack_reg    <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      osc_reg    <= osc_next;
      mask_reg   <= mask_next;
      irq_st_reg <= irq_st_next;
      rdat_reg   <= rdat_next;
      ack_reg    <= ack_next;
      irq_reg    <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // clock control state machine
  // ------------------------------------------------------------
  // a slow or stopped primary looks identical to one that never
  // started, so detection is blocked entirely while timers run
  always_comb begin
    st_next     = st_reg;
    tmr_next    = tmr_reg;
    osc_startup_status_bit_next   = osc_startup_status_bit_reg;
    pen_next    = pen_reg;
    rc_next     = rc_reg;
    mon_on_next = mon_on_reg;
    run_next    = run_reg;
    src_next    = src_reg;
    fail_det    = 1'b0;
    sw_evt      = 1'b0;
    // missing-edge counter restarts on each primary edge
    if (pclk_edge || !mon_on_reg)
      mon_next = 8'h0;
    else if (mon_reg != 8'(MON_CYC))
      mon_next = mon_reg + 8'h1;
    else
      mon_next = mon_reg;
    case (st_reg)
      FSCE_ST_START: begin
        rc_next  = 1'b1;
        pen_next = 1'b1;
        if (pm_entry) begin
          // new mode replaces a primary still starting
          pen_next = 1'b0;
          st_next  = FSCE_ST_PM;
        end else if (cfg_mode == FSCE_EXT_CLK ||
                     cfg_mode == FSCE_INT_RC) begin
          st_next     = FSCE_ST_PRIMARY;
          rc_next     = (cfg_mode == FSCE_INT_RC);
          osc_startup_status_bit_next   = 1'b1;
          mon_on_next = 1'b1;
          sw_evt      = 1'b1;
        end else if (tmr_reg == 24'((cfg_mode == FSCE_XTAL_PLL) ?
                                    TMR_MAX : OST_CYC)) begin
          st_next     = FSCE_ST_PRIMARY;
          rc_next     = 1'b0;
          osc_startup_status_bit_next   = 1'b1;
          mon_on_next = 1'b1;
          sw_evt      = 1'b1;
        end else if (pclk_edge) begin
          tmr_next    = tmr_reg + 24'h1;
        end
        // no edges: stay here, never flag a failure
      end
      FSCE_ST_PRIMARY, FSCE_ST_PM: begin
        if (mon_on_reg && mon_reg == 8'(MON_CYC) && !rc_reg) begin
          fail_det    = 1'b1;
          rc_next     = 1'b1;
          osc_startup_status_bit_next   = 1'b0;
          mon_on_next = 1'b0;
          st_next     = FSCE_ST_FAILSAFE;
        end else if (pm_entry) begin
          st_next = FSCE_ST_PM;
        end
      end
      FSCE_ST_FAILSAFE: begin
        // stays on rc, no return to failed source before power-managed entry
        if (!ctrl_reg[`FSCE_CTRL_FIE_BIT] &&
            ctrl_reg[`FSCE_CTRL_IDLE_BIT] && !run_reg && wake)
          run_next = 1'b1;
        if (pm_entry)
          st_next = FSCE_ST_PM;
      end
      default: st_next = FSCE_ST_START;
    endcase
    if (pm_entry && st_reg != FSCE_ST_START) begin
      src_next    = fsce_mode_type'(osc_reg);
      pen_next    = (osc_reg != FSCE_INT_RC);
      rc_next     = (osc_reg == FSCE_INT_RC);
      mon_on_next = 1'b1;
      osc_startup_status_bit_next   = (osc_reg != FSCE_INT_RC);
      run_next    = !ctrl_reg[`FSCE_CTRL_IDLE_BIT];
    end else if (st_reg == FSCE_ST_START && pm_entry) begin
      src_next    = fsce_mode_type'(osc_reg);
      rc_next     = 1'b1;
      mon_on_next = 1'b1;
    end else if (st_reg == FSCE_ST_START) begin
      src_next = cfg_mode;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg     <= FSCE_ST_START;
      tmr_reg    <= 24'h0;
      mon_reg    <= 8'h0;
      osc_startup_status_bit_reg   <= 1'b0;
      pen_reg    <= 1'b0;
      rc_reg     <= 1'b1;
      mon_on_reg <= 1'b0;
      run_reg    <= 1'b1;
      src_reg    <= FSCE_EXT_CLK;
    end else begin
      st_reg     <= st_next;
      tmr_reg    <= tmr_next;
      mon_reg    <= mon_next;
      osc_startup_status_bit_reg   <= osc_startup_status_bit_next;
      pen_reg    <= pen_next;
      rc_reg     <= rc_next;
      mon_on_reg <= mon_on_next;
      run_reg    <= run_next;
      src_reg    <= src_next;
    end
  end

  assign wb_dat_o  = rdat_reg;
  assign wb_ack_o  = ack_reg;
  assign prim_en_o = pen_reg;
  assign sel_rc_o  = rc_reg;
  assign clk_src_o = src_reg;
  assign mon_en_o  = mon_on_reg;
  assign cpu_run_o = run_reg;
  assign irq_o     = irq_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  rc_until_ready_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_reg == FSCE_ST_START |-> rc_reg)
    else $error("not on rc during startup");
  osc_startup_status_bit_switch_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(osc_startup_status_bit_reg) && st_reg == FSCE_ST_PRIMARY |-> mon_on_reg)
    else $error("monitor off after switchover");
  no_flag_start_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_reg == FSCE_ST_START |-> !fail_det)
    else $error("failure flagged during startup");
  fail_sets_rc_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    fail_det |=> rc_reg && irq_st_reg[`FSCE_IRQ_FAIL_BIT])
    else $error("failure not handled");
  fs_stays_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_reg == FSCE_ST_FAILSAFE && !pm_entry |=>
      st_reg == FSCE_ST_FAILSAFE && rc_reg)
    else $error("left fail-safe without cause");
  pm_src_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pm_entry |=> src_reg == fsce_mode_type'($past(osc_reg))
      && mon_on_reg)
    else $error("power-managed source wrong");
  pm_start_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pm_entry && st_reg == FSCE_ST_START |=> !pen_reg)
    else $error("primary still enabled");
  ext_fast_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_reg == FSCE_ST_START && !pm_entry && cfg_mode == FSCE_EXT_CLK
      |=> osc_startup_status_bit_reg ##0 mon_on_reg)
    else $error("ext clock not monitored at once");
  osc_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_reg == FSCE_ST_START && !osc_startup_status_bit_reg ##1 st_reg == FSCE_ST_START
      |-> osc_reg == `FSCE_OSC_CTRL_RST)
    else $error("osc control moved before ready");

endmodule

// ---- fsce_osc_model.sv ----
// behavioural primary oscillator that can be stopped on command
`timescale 1ns/1ps

// ------------------------------------------------------------
// primary oscillator model
// ------------------------------------------------------------
module fsce_osc_model #(
  parameter realtime HALF = 7.0
) (
  // control
  input  wire logic en_i,
  input  wire logic run_i,
  // clock out
  output logic      clk_o
);
  // phase unrelated to the system clock on purpose; a disabled or
  // stopped crystal stands still, so the monitor sees no edges
  initial begin
    clk_o = 1'b0;
    forever begin
      #HALF;
      if (en_i === 1'b1 && run_i === 1'b1) begin
        clk_o = ~clk_o;
      end
    end
  end
endmodule

// ---- tb_fsce_ctrl.sv ----
// self-checking bench for the fail-safe clock exit control
`timescale 1ns/1ps

module tb_fsce_ctrl;
  import fsce_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } fsce_row_type;

  logic clk_i = 1'b0, arst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, prim_clk, wake = 1'b0, run_osc = 1'b1;
  logic        prim_en, sel_rc, mon_en, cpu_run, irq;
  fsce_mode_type src, cfg = FSCE_EXT_CLK;
  int errors = 0, n_checks = 0, cyc_cnt = 0;
  fsce_row_type rows [8];

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  fsce_ctrl #(.OST_CYC(4), .PLL_CYC(4), .MON_CYC(8)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .prim_clk_i(prim_clk),
    .wake_evt_i(wake), .cfg_mode_i(cfg), .prim_en_o(prim_en),
    .sel_rc_o(sel_rc),
    .clk_src_o(src), .mon_en_o(mon_en), .cpu_run_o(cpu_run), .irq_o(irq));

  fsce_osc_model u_osc (.en_i(prim_en), .run_i(run_osc), .clk_o(prim_clk));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // the whole run needs a few hundred cycles; a hang ends here
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wait_rc(input logic exp);
    for (int i = 0; i < 200 && sel_rc !== exp; i++) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rows = '{'{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h0},
             '{8'h10, 1'b0, 32'h0, 32'h0}, '{8'h14, 1'b1, 32'h3, 32'h0},
             '{8'h04, 1'b1, 32'h1, 32'h1}, '{8'h04, 1'b1, 32'h2, 32'h2},
             '{8'h04, 1'b1, 32'h3, 32'h3}, '{8'h04, 1'b1, 32'h0, 32'h0}};
    repeat (20) @(posedge clk_i);
    chk({sel_rc, prim_en, mon_en}, 3'b100);
    arst_n_i <= 1'b1;
    // software polls startup status under its own limit
    for (int i = 0; i < 100; i++) begin
      wb(1'b0, 8'h08, 32'h0, q);
      if (q[0] === 1'b1) break;
    end
    chk(q, 32'h1d);
    foreach (rows[i]) begin
      if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d, q);
      wb(1'b0, rows[i].a, 32'h0, q);
      chk(q, rows[i].e);
    end
    $display("test registers done");

    wb(1'b1, 8'h10, 32'h1, q);
    wb(1'b1, 8'h00, 32'h4, q);
    run_osc = 1'b0;
    wait_rc(1'b1);
    chk(sel_rc, 1'b1);
    cycles(3);
    chk(irq, 1'b1);
    run_osc = 1'b1;
    cycles(40);
    chk(sel_rc, 1'b1);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk(q & 32'h1, 32'h1);
    cycles(3);
    chk(irq, 1'b0);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk(q & 32'h1, 32'h0);
    $display("test failure done");

    wb(1'b1, 8'h00, 32'hc, q);
    cycles(4);
    chk({src, mon_en, sel_rc}, {FSCE_EXT_CLK, 2'b10});
    run_osc = 1'b0;
    wait_rc(1'b1);
    chk({sel_rc, cpu_run}, 2'b11);
    run_osc = 1'b1;
    cycles(40);
    chk(sel_rc, 1'b1);
    $display("test power managed done");

    wb(1'b1, 8'h00, 32'h18, q);
    cycles(4);
    run_osc = 1'b0;
    repeat (30) @(posedge clk_i);
    chk(cpu_run, 1'b0);
    wake <= 1'b1;
    repeat (4) @(posedge clk_i);
    wake <= 1'b0;
    for (int i = 0; i < 50 && cpu_run !== 1'b1; i++) @(posedge clk_i);
    cycles(1);
    chk({cpu_run, sel_rc}, 2'b11);
    run_osc = 1'b1;
    $display("test idle wake done");

    @(posedge clk_i);
    arst_n_i <= 1'b0;
    cycles(3);
    chk({sel_rc, prim_en, mon_en}, 3'b100);
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    wait_rc(1'b0);
    cycles(4);
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h1d);
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h0);
    $display("test second reset done");

    @(posedge clk_i);
    arst_n_i <= 1'b0;
    cfg <= FSCE_XTAL;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h1a);
    wb(1'b1, 8'h04, 32'h2, q);
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h0);
    wait_rc(1'b0);
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h1d);
    $display("test crystal start done");

    @(posedge clk_i);
    arst_n_i <= 1'b0;
    cfg <= FSCE_XTAL_PLL;
    run_osc = 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      wb(1'b0, 8'h08, 32'h0, q);
      if (q[0] === 1'b1) break;
    end
    chk(q, 32'h1a);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, 8'h00, 32'h8, q);
    cycles(4);
    chk({prim_en, sel_rc, mon_en}, 3'b011);
    run_osc = 1'b1;
    $display("test never start done");
    close_out();
  end
endmodule
